// file: src/phy_diag_pkg.sv
`default_nettype none

package phy_diag_pkg;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_TENBASE_STATUS_CONTROL = 6'h1A;
  localparam logic [5:0] IDX_SELFTEST_ERROR_GAP     = 6'h1B;
  localparam logic [5:0] IDX_SELFTEST_PACKET_LENGTH = 6'h1C;
  localparam logic [5:0] IDX_CABLE_DIAG_CONTROL     = 6'h1E;

  // ==========================================================================
  // Field positions
  localparam int TEN_LOWER_THRESH_BIT = 13;
  localparam int TEN_SQUELCH_LSB      = 9;
  localparam int TEN_SQUELCH_W        = 4;
  localparam int TEN_SPARE_BIT        = 8;
  localparam int TEN_NLP_DISABLE_BIT  = 7;
  localparam int TEN_POLARITY_BIT     = 4;
  localparam int TEN_JABBER_DIS_BIT   = 0;
  localparam int ERR_CAPTURE_BIT      = 15;
  localparam int ERR_COUNT_LSB        = 8;
  localparam int ERR_COUNT_W          = 8;
  localparam int GAP_LSB              = 0;
  localparam int GAP_W                = 8;
  localparam int PKT_LEN_LSB          = 0;
  localparam int PKT_LEN_W            = 11;
  localparam int CDG_START_BIT        = 15;
  localparam int CDG_DONE_BIT         = 1;
  localparam int CDG_FAIL_BIT         = 0;

  // ==========================================================================
  // Values after reset, and the error count ceiling
  localparam logic [3:0]  RST_SQUELCH  = 4'h0;
  localparam logic [7:0]  RST_GAP      = 8'h7D;
  localparam logic [10:0] RST_PKT_LEN  = 11'h5EE;
  localparam logic        RST_CDG_DONE = 1'b1;
  localparam logic        RST_CDG_FAIL = 1'b0;
  localparam logic [7:0]  ERR_COUNT_MAX = 8'hFF;

  // ==========================================================================
  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

endpackage

`default_nettype wire

// file: src/pin_sync.sv
`default_nettype none

// ==========================================================================
// Three-stage synchroniser; output follows once stages two and three agree
module pin_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      level_out
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
    end else begin
      stage1_r <= pin_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_out <= 1'b0;
    end else if (stage2_r == stage3_r) begin
      level_out <= stage3_r;
    end
  end

endmodule

`default_nettype wire

// file: src/error_counter.sv
`default_nettype none

// ==========================================================================
// Errored-byte counter with clear, saturate or wrap
module error_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clear,
  input  wire logic             incr,
  input  wire logic             wrap_mode,
  output logic [WIDTH-1:0]      count
);

  if (WIDTH < 1) begin : g_width_check
    $error("error_counter: WIDTH must be at least 1");
  end

  logic [WIDTH-1:0] base;

  // An error in the clear cycle is counted, not lost
  always_comb begin
    base = clear ? '0 : count;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (incr) begin
      if (&base && !wrap_mode) begin
        count <= base;
      end else begin
        count <= base + WIDTH'(1);
      end
    end else begin
      count <= base;
    end
  end

endmodule

`default_nettype wire

// file: src/phy_diag_control_regs.sv
`default_nettype none

// ==========================================================================
// Diagnostic and 10Base-Te control registers behind an APB slave
module phy_diag_control_regs
  import phy_diag_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              polarity_inverted_pin,
  input  wire logic              prbs_byte_error,
  input  wire logic              error_counter_wrap,
  input  wire logic              tenbase_mode,
  input  wire logic              cable_diag_done,
  input  wire logic              cable_diag_fail,
  output logic                   lower_threshold_en,
  output logic [3:0]             squelch_sel,
  output logic                   nlp_disable,
  output logic                   jabber_enable,
  output logic                   polarity_status,
  output logic [7:0]             selftest_ipg,
  output logic [10:0]            selftest_packet_len,
  output logic                   cable_diag_start
);

  // Elaboration refuses an address too narrow for the register indices
  if (ADDR_W < 8) begin : g_addr_w_check
    $error("phy_diag_control_regs: ADDR_W must be at least 8");
  end

  // ==========================================================================
  // Decode and write helpers
  typedef enum logic [2:0] {
    SEL_NONE    = 3'b000,
    SEL_TENBASE = 3'b001,
    SEL_ERR_GAP = 3'b010,
    SEL_PKT_LEN = 3'b011,
    SEL_CABLE   = 3'b100
  } reg_sel_t;

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    // Any upper address bit set falls outside the register block
    if (addr[1:0] == 2'b00 && (addr >> 8) == '0) begin
      if (addr[7:2] == IDX_TENBASE_STATUS_CONTROL) begin
        sel = SEL_TENBASE;
      end else if (addr[7:2] == IDX_SELFTEST_ERROR_GAP) begin
        sel = SEL_ERR_GAP;
      end else if (addr[7:2] == IDX_SELFTEST_PACKET_LENGTH) begin
        sel = SEL_PKT_LEN;
      end else if (addr[7:2] == IDX_CABLE_DIAG_CONTROL) begin
        sel = SEL_CABLE;
      end
    end
    return sel;
  endfunction

  // Merge write data into a 16-bit image under the two low byte strobes
  function automatic logic [15:0] merge(input logic [15:0] old_val,
                                        input logic [31:0] wdata,
                                        input logic [3:0]  strb);
    logic [15:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

  // ==========================================================================
  // Bus phases
  reg_sel_t    sel_now;
  logic        setup_phase;
  logic        access_done;
  logic        wr_done;
  logic        rd_done;
  reg_sel_t    sel_r;
  logic        err_r;
  logic [15:0] rd_data_nxt;
  logic [15:0] ten_image;
  logic [15:0] gap_image;
  logic [15:0] len_image;
  logic [15:0] cdg_image;
  logic [15:0] ten_wr;
  logic [15:0] gap_wr;
  logic [15:0] len_wr;
  logic [15:0] cdg_wr;

  assign sel_now     = decode(paddr);
  assign setup_phase = psel && !penable;
  // No wait states: every access cycle completes the transfer
  assign pready      = psel && penable;
  assign access_done = psel && penable && pready;
  assign wr_done     = access_done && pwrite && !err_r;
  assign rd_done     = access_done && !pwrite && !err_r;
  assign pslverr     = psel && penable && err_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= SEL_NONE;
      err_r <= 1'b0;
    end else if (setup_phase) begin
      sel_r <= sel_now;
      err_r <= (sel_now == SEL_NONE);
    end
  end

  // ==========================================================================
  // 10Base-Te controls
  logic       lower_thresh_r;
  logic [3:0] squelch_r;
  logic       spare_r;
  logic       nlp_dis_r;
  logic       jabber_dis_r;
  logic       polarity_r;
  logic       polarity_seen;
  logic       polarity_read_r;

  assign ten_wr = merge(ten_image, pwdata, pstrb);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_thresh_r <= 1'b0;
      squelch_r      <= RST_SQUELCH;
      spare_r        <= 1'b0;
      nlp_dis_r      <= 1'b0;
      jabber_dis_r   <= 1'b0;
    end else if (wr_done && sel_r == SEL_TENBASE) begin
      lower_thresh_r <= ten_wr[TEN_LOWER_THRESH_BIT];
      squelch_r      <= ten_wr[TEN_SQUELCH_LSB +: TEN_SQUELCH_W];
      spare_r        <= ten_wr[TEN_SPARE_BIT];
      nlp_dis_r      <= ten_wr[TEN_NLP_DISABLE_BIT];
      jabber_dis_r   <= ten_wr[TEN_JABBER_DIS_BIT];
    end
  end

  pin_sync u_polarity_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (polarity_inverted_pin),
    .level_out (polarity_seen)
  );

  // Only the value that went out on the bus is cleared, so a detection
  // after the snapshot survives the read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polarity_r <= 1'b0;
    end else if (polarity_seen) begin
      polarity_r <= 1'b1;
    end else if (rd_done && sel_r == SEL_TENBASE && polarity_read_r) begin
      polarity_r <= 1'b0;
    end
  end

  // Polarity bit as it went into the read data snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polarity_read_r <= 1'b0;
    end else if (setup_phase) begin
      polarity_read_r <= polarity_r;
    end
  end

  // ==========================================================================
  // Self-test error counter and sizing
  logic [7:0]  err_count;
  logic [7:0]  err_latched_r;
  logic        capture;
  logic [7:0]  gap_r;
  logic [10:0] pkt_len_r;

  assign gap_wr  = merge(gap_image, pwdata, pstrb);
  assign len_wr  = merge(len_image, pwdata, pstrb);
  assign capture = wr_done && sel_r == SEL_ERR_GAP && pstrb[1] && pwdata[ERR_CAPTURE_BIT];

  error_counter #(
    .WIDTH (ERR_COUNT_W)
  ) u_error_counter (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (capture),
    .incr      (prbs_byte_error),
    .wrap_mode (error_counter_wrap),
    .count     (err_count)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_latched_r <= 8'h00;
    end else if (capture) begin
      err_latched_r <= err_count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= RST_GAP;
    end else if (wr_done && sel_r == SEL_ERR_GAP) begin
      gap_r <= gap_wr[GAP_LSB +: GAP_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_len_r <= RST_PKT_LEN;
    end else if (wr_done && sel_r == SEL_PKT_LEN) begin
      pkt_len_r <= len_wr[PKT_LEN_LSB +: PKT_LEN_W];
    end
  end

  // ==========================================================================
  // Cable diagnostic handshake
  logic cdg_start_r;
  logic cdg_done_r;
  logic cdg_fail_r;
  logic start_req;
  logic finish;

  assign cdg_wr    = merge(cdg_image, pwdata, pstrb);
  assign start_req = wr_done && sel_r == SEL_CABLE && pstrb[1] && cdg_wr[CDG_START_BIT];
  assign finish    = cdg_start_r && cable_diag_done;

  // A start write in the finishing cycle begins a fresh measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdg_start_r <= 1'b0;
    end else if (start_req) begin
      cdg_start_r <= 1'b1;
    end else if (wr_done && sel_r == SEL_CABLE && pstrb[1]) begin
      cdg_start_r <= 1'b0;
    end else if (finish) begin
      cdg_start_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cdg_done_r <= RST_CDG_DONE;
      cdg_fail_r <= RST_CDG_FAIL;
    end else if (start_req) begin
      cdg_done_r <= 1'b0;
      cdg_fail_r <= 1'b0;
    end else if (finish) begin
      cdg_done_r <= 1'b1;
      cdg_fail_r <= cable_diag_fail;
    end
  end

  // ==========================================================================
  // Register images and read path
  always_comb begin
    ten_image = 16'h0000;
    ten_image[TEN_LOWER_THRESH_BIT] = lower_thresh_r;
    ten_image[TEN_SQUELCH_LSB +: TEN_SQUELCH_W] = squelch_r;
    ten_image[TEN_SPARE_BIT] = spare_r;
    ten_image[TEN_NLP_DISABLE_BIT] = nlp_dis_r;
    ten_image[TEN_POLARITY_BIT] = polarity_r;
    ten_image[TEN_JABBER_DIS_BIT] = jabber_dis_r;
  end

  always_comb begin
    gap_image = 16'h0000;
    gap_image[ERR_COUNT_LSB +: ERR_COUNT_W] = err_latched_r;
    gap_image[GAP_LSB +: GAP_W] = gap_r;
  end

  always_comb begin
    len_image = 16'h0000;
    len_image[PKT_LEN_LSB +: PKT_LEN_W] = pkt_len_r;
  end

  always_comb begin
    cdg_image = 16'h0000;
    cdg_image[CDG_START_BIT] = cdg_start_r;
    cdg_image[CDG_DONE_BIT] = cdg_done_r;
    cdg_image[CDG_FAIL_BIT] = cdg_fail_r;
  end

  always_comb begin
    unique case (sel_now)
      SEL_TENBASE: rd_data_nxt = ten_image;
      SEL_ERR_GAP: rd_data_nxt = gap_image;
      SEL_PKT_LEN: rd_data_nxt = len_image;
      SEL_CABLE:   rd_data_nxt = cdg_image;
      default:     rd_data_nxt = 16'h0000;
    endcase
  end

  // Read data is snapshot in the setup cycle and held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= {16'h0000, rd_data_nxt};
    end
  end

  // ==========================================================================
  // Control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_threshold_en  <= 1'b0;
      squelch_sel         <= RST_SQUELCH;
      nlp_disable         <= 1'b0;
      jabber_enable       <= 1'b0;
      polarity_status     <= 1'b0;
      selftest_ipg        <= RST_GAP;
      selftest_packet_len <= RST_PKT_LEN;
      cable_diag_start    <= 1'b0;
    end else begin
      lower_threshold_en  <= lower_thresh_r;
      squelch_sel         <= squelch_r;
      nlp_disable         <= nlp_dis_r;
      // Jabber control only acts while the link runs 10Base-Te
      jabber_enable       <= tenbase_mode && !jabber_dis_r;
      polarity_status     <= polarity_r;
      selftest_ipg        <= gap_r;
      selftest_packet_len <= pkt_len_r;
      cable_diag_start    <= cdg_start_r;
    end
  end

endmodule

`default_nettype wire

// file: verification/phy_diag_control_regs_props.sv
`default_nettype none

// ==========================================================================
// Port checks of the diagnostic register block
module phy_diag_control_regs_props
  import phy_diag_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              polarity_inverted_pin,
  input wire logic              tenbase_mode,
  input wire logic              cable_diag_done,
  input wire logic              lower_threshold_en,
  input wire logic [3:0]        squelch_sel,
  input wire logic              nlp_disable,
  input wire logic              jabber_enable,
  input wire logic              polarity_status,
  input wire logic [7:0]        selftest_ipg,
  input wire logic [10:0]       selftest_packet_len,
  input wire logic              cable_diag_start
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire logic acc   = psel && penable && pwrite;
  wire logic w_ten = acc && paddr == ADDR_W'({IDX_TENBASE_STATUS_CONTROL, 2'b00});
  wire logic w_gap = acc && paddr == ADDR_W'({IDX_SELFTEST_ERROR_GAP, 2'b00});
  wire logic w_len = acc && paddr == ADDR_W'({IDX_SELFTEST_PACKET_LENGTH, 2'b00});
  wire logic w_cdg = acc && paddr == ADDR_W'({IDX_CABLE_DIAG_CONTROL, 2'b00});

  chk_thresh_follows:
    assert property (w_ten && pstrb[1] |-> ##2 lower_threshold_en == $past(pwdata[13], 2))
    else $error("threshold enable does not follow its write");
  chk_squelch_follows:
    assert property (w_ten && pstrb[1] |-> ##2 squelch_sel == $past(pwdata[12:9], 2))
    else $error("squelch select does not follow its write");
  chk_nlp_follows:
    assert property (w_ten && pstrb[0] |-> ##2 nlp_disable == $past(pwdata[7], 2))
    else $error("link pulse disable does not follow its write");
  chk_jabber_gated:
    assert property (w_ten && pstrb[0] |-> ##2
      jabber_enable == ($past(tenbase_mode) && !$past(pwdata[0], 2)))
    else $error("jabber enable wrong after write");
  chk_polarity_seen:
    assert property (polarity_inverted_pin [*8] |-> polarity_status)
    else $error("inverted polarity not reported");
  chk_gap_follows:
    assert property (w_gap && pstrb[0] |-> ##2 selftest_ipg == $past(pwdata[7:0], 2))
    else $error("gap output does not follow its write");
  chk_length_follows:
    assert property (w_len && pstrb[1:0] == 2'b11 |-> ##2
      selftest_packet_len == $past(pwdata[10:0], 2))
    else $error("packet length does not follow its write");
  chk_start_sets:
    assert property (w_cdg && pstrb[1] && pwdata[15] |-> ##2 cable_diag_start)
    else $error("cable start not raised by write");
  chk_start_clears:
    assert property (cable_diag_done && !w_cdg |-> ##2 !cable_diag_start)
    else $error("cable start not cleared by done");
endmodule

bind phy_diag_control_regs phy_diag_control_regs_props #(.ADDR_W(ADDR_W)) chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .polarity_inverted_pin, .tenbase_mode, .cable_diag_done, .lower_threshold_en,
  .squelch_sel, .nlp_disable, .jabber_enable, .polarity_status, .selftest_ipg,
  .selftest_packet_len, .cable_diag_start);

`default_nettype wire

// file: verification/tb.sv
`default_nettype none

module tb
  import phy_diag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        pol_pin = 1'b0;
  logic        prbs_err = 1'b0;
  logic        wrap = 1'b0;
  logic        ten_mode = 1'b1;
  logic        cd_done = 1'b0;
  logic        cd_fail = 1'b0;
  logic        pready, pslverr, thr, nlp, jab, pol, cd_start, er;
  logic [31:0] prdata, rd;
  logic [3:0]  sq;
  logic [7:0]  ipg;
  logic [10:0] plen;
  logic [15:0] seed = 16'h003F;
  int          n_fail = 0;
  int          checked = 0;
  int          ten_m = 0, gap_m = 32'h7D, len_m = 32'h5EE, cdg_m = 2, cnt_m = 0, lat_m = 0;
  logic [7:0]  regs [6] = '{8'h68, 8'h6C, 8'h70, 8'h78, 8'h74, 8'h69};

  phy_diag_control_regs uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .polarity_inverted_pin(pol_pin),
    .prbs_byte_error(prbs_err), .error_counter_wrap(wrap), .tenbase_mode(ten_mode),
    .cable_diag_done(cd_done), .cable_diag_fail(cd_fail), .lower_threshold_en(thr),
    .squelch_sel(sq), .nlp_disable(nlp), .jabber_enable(jab), .polarity_status(pol),
    .selftest_ipg(ipg), .selftest_packet_len(plen), .cable_diag_start(cd_start));

  initial begin
    forever #10 pclk = ~pclk;
  end

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int merge(input int old, input int d, input logic [3:0] s, input int m);
    int r;
    r = old;
    if (s[0]) r = (r & ~(m & 32'hFF)) | (d & m & 32'hFF);
    if (s[1]) r = (r & ~(m & 32'hFF00)) | (d & m & 32'hFF00);
    return r;
  endfunction

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] s);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) cmp("ready wait", 1, 0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
    case (a)
      8'h68: ten_m = merge(ten_m, d, s, 32'h3F81);
      8'h6C: begin
        gap_m = merge(gap_m, d, s, 32'h00FF);
        if (s[1] && d[15]) begin
          lat_m = cnt_m;
          cnt_m = 0;
        end
      end
      8'h70: len_m = merge(len_m, d, s, 32'h07FF);
      8'h78: if (s[1]) cdg_m = d[15] ? 32'h8000 : cdg_m & 32'h3;
      default: ;
    endcase
    cmp("write error", !(a inside {8'h68, 8'h6C, 8'h70, 8'h78}), er);
  endtask

  task automatic rdchk(input logic [7:0] a);
    logic [31:0] e;
    apb(1'b0, a, 16'h0000, 4'h0);
    case (a)
      8'h68: e = ten_m;
      8'h6C: e = (lat_m << 8) | gap_m;
      8'h70: e = len_m;
      8'h78: e = cdg_m;
      default: e = 0;
    endcase
    cmp("read data", e, rd);
    cmp("read error", !(a inside {8'h68, 8'h6C, 8'h70, 8'h78}), er);
  endtask

  task automatic outchk;
    repeat (2) @(posedge pclk);
    cmp("threshold", ten_m[13], thr);
    cmp("squelch", ten_m[12:9], sq);
    cmp("link pulse disable", ten_m[7], nlp);
    cmp("jabber enable", ten_mode & ~ten_m[0], jab);
    cmp("gap", gap_m[7:0], ipg);
    cmp("packet length", len_m[10:0], plen);
    cmp("cable start", cdg_m[15], cd_start);
  endtask

  task automatic errs(input int n);
    repeat (n) begin
      @(posedge pclk);
      prbs_err <= 1'b1;
    end
    @(posedge pclk);
    prbs_err <= 1'b0;
    cnt_m = wrap ? (cnt_m + n) % 256 : ((cnt_m + n > 255) ? 255 : cnt_m + n);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rdchk(regs[i]);
    outchk();
    for (int i = 0; i < 30; i++) begin
      seed = lfsr(seed);
      ten_mode <= seed[3];
      wr(regs[i % 6], lfsr(seed), seed[7:4]);
      rdchk(regs[i % 6]);
      outchk();
    end
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(regs[i], seed & 16'h7FFF, 4'h3);
    end
    outchk();
    pol_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    cmp("polarity out", 1, pol);
    ten_m = ten_m | 32'h10;
    rdchk(8'h68);
    pol_pin <= 1'b0;
    repeat (10) @(posedge pclk);
    rdchk(8'h68);
    ten_m = ten_m & ~32'h10;
    repeat (3) @(posedge pclk);
    cmp("polarity out", 0, pol);
    rdchk(8'h68);
    wrap <= 1'b0;
    errs(300);
    wr(8'h6C, 16'h8000, 4'h2);
    rdchk(8'h6C);
    errs(5);
    wr(8'h6C, 16'h8000, 4'h2);
    rdchk(8'h6C);
    wrap <= 1'b1;
    errs(260);
    wr(8'h6C, 16'h8000, 4'h2);
    rdchk(8'h6C);
    for (int f = 1; f >= 0; f--) begin
      wr(8'h78, 16'h8000, 4'h2);
      rdchk(8'h78);
      cd_fail <= f[0];
      cd_done <= 1'b1;
      @(posedge pclk);
      cd_done <= 1'b0;
      cdg_m = f ? 3 : 2;
      rdchk(8'h78);
      outchk();
    end
    wr(8'h78, 16'h8000, 4'h2);
    wr(8'h78, 16'h0000, 4'h2);
    cd_done <= 1'b1;
    @(posedge pclk);
    cd_done <= 1'b0;
    rdchk(8'h78);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
endmodule

`default_nettype wire
